// File: slp_pkg.sv
package slp_pkg;

    // ------------------------------------------------------------
    // Port state and mode
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SLP_DIS, SLP_ENA, SLP_RDY, SLP_CHK}
        slp_state_t;
    typedef enum logic [1:0] {SLP_NORMAL, SLP_PRIV, SLP_WRAP}
        slp_mode_t;

    // ------------------------------------------------------------
    // Codes on the ports
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_CODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_CODE_PRIV   = 2'h1;
    localparam logic [1:0] MODE_CODE_WRAP   = 2'h2;
    localparam logic [1:0] FT_CONTROL       = 2'h0;
    localparam logic [1:0] FT_PRIV          = 2'h1;
    localparam logic [1:0] FT_RESV          = 2'h2;
    localparam logic [1:0] FT_APP           = 2'h3;
    localparam logic [1:0] AL_NONE          = 2'h0;
    localparam logic [1:0] AL_PORT_UP       = 2'h1;
    localparam logic [1:0] AL_TGT_DOWN      = 2'h2;
    localparam logic [1:0] AL_WRAP_RX       = 2'h3;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STAT   = 8'h04;
    localparam logic [7:0] OFS_ROUTE0 = 8'h08;
    localparam logic [7:0] OFS_ROUTE1 = 8'h0c;
    localparam int CB_ENABLE   = 0;
    localparam int CB_SELFTEST = 1;
    localparam int CB_RESET    = 2;
    localparam int CB_MODE_GO  = 3;
    localparam int CB_MODE_LO  = 4;
    localparam int RT_VALID    = 31;
    localparam int RT_PORT     = 30;
    localparam int RT_ROUTE_LO = 16;
    localparam int NPORTS      = 2;
    localparam int ROUTE_W     = 8;
    localparam int TAG_W       = 16;
    localparam int STAT_W      = 15;
    localparam logic [1:0] SEQ_INIT = 2'h0;

endpackage : slp_pkg

// File: slp_port_ctrl.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps

module slp_port_ctrl #(
    parameter bit PORT_NUM = 1'b0
) (
    input  wire logic                       CLK,
    input  wire logic                       RST,
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [7:0]                 PADDR,
    input  wire logic [31:0]                PWDATA,
    output logic      [31:0]                PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    input  wire logic                       ERR_DET,
    input  wire logic                       PEER_RST_RX,
    input  wire logic                       LINE_FAULT,
    input  wire logic                       FLAG_RX,
    input  wire logic                       ERP_DONE_OK,
    input  wire logic                       ERP_DONE_ALERT,
    input  wire logic                       ERP_DISABLE,
    input  wire logic                       RESET_FRAME_RX,
    input  wire logic                       SETUP_VALID,
    input  wire logic [1:0]                 SETUP_MODE,
    input  wire logic                       SETUP_PORT,
    input  wire logic                       SETUP_RX_PORT,
    input  wire logic [slp_pkg::ROUTE_W-1:0] SETUP_ROUTE,
    input  wire logic [slp_pkg::TAG_W-1:0]  SETUP_TAG,
    input  wire logic                       TX_REQ,
    input  wire logic [1:0]                 TX_TYPE,
    input  wire logic                       TX_IS_RESET,
    input  wire logic                       RX_FRAME,
    input  wire logic [1:0]                 RX_TYPE,
    input  wire logic                       RX_FOR_PORT,
    input  wire logic                       RR_RX,
    input  wire logic                       ACK_RX,
    input  wire logic                       PAIR_SENT,
    input  wire logic                       FWD_REQ,
    input  wire logic [1:0]                 FWD_TYPE,
    input  wire logic                       FWD_IS_RESET,
    input  wire logic                       TXD_IN,
    input  wire logic                       LINE_IN,
    output logic                            LINE_OUT,
    output logic                            RXD_OUT,
    output logic                            TX_GRANT,
    output logic                            TX_DROP,
    output logic                            TX_HOLD,
    output logic                            SEND_FLAG,
    output logic                            SEND_DIS,
    output logic                            RX_ACCEPT,
    output logic                            RX_DROP,
    output logic                            RX_ACK,
    output logic                            FWD_PASS,
    output logic                            FWD_DROP,
    output logic                            ERP_START,
    output logic                            ALERT_VALID,
    output logic      [1:0]                 ALERT_CODE
);

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    slp_pkg::slp_state_t state_reg, state_next;
    slp_pkg::slp_mode_t  mode_reg,  mode_next;
    logic [1:0]  tx_seq_reg, rx_seq_reg;
    logic        usable_reg, usable_next;
    logic        awaiting_receive_ready_reg, receive_ready_owed_reg;
    logic        awaiting_ack_reg, ack_owed_reg;
    logic        peer_rst_seen_reg, err_latch_reg, pready_reg;
    logic        alert_entry_valid [slp_pkg::NPORTS];
    logic        alert_out_port    [slp_pkg::NPORTS];
    logic [slp_pkg::ROUTE_W-1:0] alert_return_route [slp_pkg::NPORTS];
    logic [slp_pkg::TAG_W-1:0]   alert_tag          [slp_pkg::NPORTS];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire wr_fire  = PSEL & PENABLE & PWRITE & pready_reg;
    wire hit_ctrl = PADDR == slp_pkg::OFS_CTRL;
    wire hit_stat = PADDR == slp_pkg::OFS_STAT;
    wire hit_rt0  = PADDR == slp_pkg::OFS_ROUTE0;
    wire hit_rt1  = PADDR == slp_pkg::OFS_ROUTE1;
    wire hit_any  = hit_ctrl | hit_stat | hit_rt0 | hit_rt1;
    wire ctrl_wr  = wr_fire & hit_ctrl;
    wire en_go    = ctrl_wr & PWDATA[slp_pkg::CB_ENABLE];
    wire st_bit   = ctrl_wr & PWDATA[slp_pkg::CB_SELFTEST];
    wire mst_go   = ctrl_wr & PWDATA[slp_pkg::CB_MODE_GO];
    wire [1:0] mst_mode = PWDATA[slp_pkg::CB_MODE_LO +: 2];

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    wire in_wrap  = mode_reg == slp_pkg::SLP_WRAP;
    wire in_priv  = mode_reg == slp_pkg::SLP_PRIV;
    wire in_rdy   = state_reg == slp_pkg::SLP_RDY;
    wire in_chk   = state_reg == slp_pkg::SLP_CHK;
    wire port_rst = (ctrl_wr & PWDATA[slp_pkg::CB_RESET]) | RESET_FRAME_RX;
    wire st_go    = st_bit & in_wrap;
    wire fault_ok = LINE_FAULT & ~in_wrap;
    wire erp_alert = ERP_DONE_ALERT & in_chk;
    wire setup_me = SETUP_VALID & (SETUP_PORT == PORT_NUM);
    wire enter_dis = (state_next == slp_pkg::SLP_DIS) &
                     (state_reg != slp_pkg::SLP_DIS);
    wire enter_rdy = (state_next == slp_pkg::SLP_RDY) & ~in_rdy;
    wire enter_chk = (state_next == slp_pkg::SLP_CHK) & ~in_chk;
    wire enter_wrap = (mode_next == slp_pkg::SLP_WRAP) & ~in_wrap;

    wire rx_np  = RX_TYPE != slp_pkg::FT_CONTROL;
    wire rx_ar  = (RX_TYPE == slp_pkg::FT_APP) |
                  (RX_TYPE == slp_pkg::FT_RESV);
    wire rx_wrap_drop = RX_FRAME & in_wrap & RX_FOR_PORT;
    wire rx_hold_drop = RX_FRAME & rx_np & ~in_rdy;
    wire rx_ok   = RX_FRAME & ~rx_wrap_drop & ~rx_hold_drop;
    wire rx_priv_drop = rx_ok & in_priv & rx_ar;
    wire rr_eff  = RR_RX & ~in_chk;

    wire tx_np   = TX_TYPE != slp_pkg::FT_CONTROL;
    wire tx_ar   = (TX_TYPE == slp_pkg::FT_APP) |
                   (TX_TYPE == slp_pkg::FT_RESV);
    wire tx_rst_ok = ~tx_np & TX_IS_RESET;
    wire tx_priv_drop = TX_REQ & in_priv & tx_ar;
    wire tx_state_ok = (in_rdy & (~tx_np | ~awaiting_receive_ready_reg)) |
                       (in_chk & ~tx_np);
    wire tx_grant = TX_REQ & ~tx_priv_drop &
                    (tx_rst_ok | (usable_reg & tx_state_ok));

    wire fwd_ap  = (FWD_TYPE == slp_pkg::FT_APP) |
                   (FWD_TYPE == slp_pkg::FT_PRIV);
    wire fwd_pass = FWD_REQ & (~fwd_ap | usable_reg |
                               (FWD_IS_RESET & ~fwd_ap));
    wire fwd_drop = FWD_REQ & fwd_ap & ~usable_reg;
    wire port_up  = usable_next & ~usable_reg;

    // ------------------------------------------------------------
    // State and mode selection
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            slp_pkg::SLP_DIS: begin
                if (en_go) state_next = slp_pkg::SLP_ENA;
            end
            slp_pkg::SLP_ENA: begin
                if (fault_ok) state_next = slp_pkg::SLP_CHK;
                else if (FLAG_RX) state_next = slp_pkg::SLP_RDY;
            end
            slp_pkg::SLP_RDY: begin
                if (ERR_DET | PEER_RST_RX)
                    state_next = slp_pkg::SLP_CHK;
            end
            slp_pkg::SLP_CHK: begin
                if (ERP_DONE_OK) state_next = slp_pkg::SLP_RDY;
                else if (ERP_DONE_ALERT) state_next = slp_pkg::SLP_DIS;
            end
            default: state_next = slp_pkg::SLP_DIS;
        endcase
        if (port_rst | ERP_DISABLE | st_go)
            state_next = slp_pkg::SLP_DIS;
    end

    always_comb begin
        mode_next = mode_reg;
        if (mst_go) begin
            case (mst_mode)
                slp_pkg::MODE_CODE_NORMAL: mode_next = slp_pkg::SLP_NORMAL;
                slp_pkg::MODE_CODE_PRIV:   mode_next = slp_pkg::SLP_PRIV;
                slp_pkg::MODE_CODE_WRAP:   mode_next = slp_pkg::SLP_WRAP;
                default:                   mode_next = mode_reg;
            endcase
        end
        if (setup_me) begin
            case (SETUP_MODE)
                slp_pkg::MODE_CODE_NORMAL: begin
                    if (in_priv) mode_next = slp_pkg::SLP_NORMAL;
                end
                slp_pkg::MODE_CODE_PRIV: mode_next = slp_pkg::SLP_PRIV;
                slp_pkg::MODE_CODE_WRAP: mode_next = slp_pkg::SLP_WRAP;
                default: mode_next = mode_reg;
            endcase
        end
        if (erp_alert & (mode_reg == slp_pkg::SLP_NORMAL))
            mode_next = slp_pkg::SLP_PRIV;
        if (st_go | RESET_FRAME_RX)
            mode_next = slp_pkg::SLP_PRIV;
    end

    always_comb begin
        usable_next = usable_reg;
        if (port_rst | erp_alert | enter_wrap)
            usable_next = 1'b0;
        if (enter_rdy & (mode_next != slp_pkg::SLP_WRAP))
            usable_next = 1'b1;
        if (mode_next == slp_pkg::SLP_WRAP)
            usable_next = 1'b0;
    end

    // ------------------------------------------------------------
    // Port state, mode and flags
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg  <= slp_pkg::SLP_DIS;
            mode_reg   <= slp_pkg::SLP_WRAP;
            usable_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            mode_reg   <= mode_next;
            usable_reg <= usable_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST | enter_dis) begin
            tx_seq_reg <= slp_pkg::SEQ_INIT;
            rx_seq_reg <= slp_pkg::SEQ_INIT;
        end else begin
            if (tx_grant) tx_seq_reg <= tx_seq_reg + 2'h1;
            if (rx_ok) rx_seq_reg <= rx_seq_reg + 2'h1;
        end
    end

    // Disabled entry wins; otherwise sets win over clears on the same edge
    always_ff @(posedge CLK) begin
        if (RST) begin
            awaiting_receive_ready_reg <= 1'b1;
            receive_ready_owed_reg     <= 1'b1;
            awaiting_ack_reg           <= 1'b0;
            ack_owed_reg               <= 1'b0;
        end else if (enter_dis) begin
            awaiting_receive_ready_reg <= 1'b1;
            receive_ready_owed_reg     <= 1'b1;
            awaiting_ack_reg           <= 1'b0;
            ack_owed_reg               <= 1'b0;
        end else begin
            if (tx_grant & tx_np) awaiting_receive_ready_reg <= 1'b1;
            else if (rr_eff) awaiting_receive_ready_reg <= 1'b0;
            if (rx_ok & rx_np) receive_ready_owed_reg <= 1'b1;
            else if (PAIR_SENT) receive_ready_owed_reg <= 1'b0;
            if (tx_grant) awaiting_ack_reg <= 1'b1;
            else if (ACK_RX) awaiting_ack_reg <= 1'b0;
            if (rx_ok) ack_owed_reg <= 1'b1;
            else if (PAIR_SENT) ack_owed_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            peer_rst_seen_reg <= 1'b0;
            err_latch_reg     <= 1'b0;
        end else begin
            if (PEER_RST_RX & (state_reg != slp_pkg::SLP_DIS))
                peer_rst_seen_reg <= 1'b1;
            else if (enter_dis) peer_rst_seen_reg <= 1'b0;
            if (ERR_DET) err_latch_reg <= 1'b1;
            else if (enter_dis) err_latch_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Alert routing table
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        for (int i = 0; i < slp_pkg::NPORTS; i++) begin
            if (RST) begin
                alert_entry_valid[i]  <= 1'b0;
                alert_out_port[i]     <= 1'b0;
                alert_return_route[i] <= '0;
                alert_tag[i]          <= '0;
            end else if (SETUP_VALID & (int'(SETUP_PORT) == i)) begin
                alert_entry_valid[i]  <= 1'b1;
                alert_out_port[i]     <= SETUP_RX_PORT;
                alert_return_route[i] <= SETUP_ROUTE;
                alert_tag[i]          <= SETUP_TAG;
            end
        end
    end

    // ------------------------------------------------------------
    // Link-side outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            LINE_OUT <= 1'b0;
            RXD_OUT  <= 1'b0;
        end else begin
            LINE_OUT <= in_wrap ? 1'b0 : TXD_IN;
            RXD_OUT  <= in_wrap ? TXD_IN : LINE_IN;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            TX_GRANT  <= 1'b0;
            TX_DROP   <= 1'b0;
            TX_HOLD   <= 1'b0;
            SEND_FLAG <= 1'b0;
            SEND_DIS  <= 1'b1;
            RX_ACCEPT <= 1'b0;
            RX_DROP   <= 1'b0;
            RX_ACK    <= 1'b0;
            FWD_PASS  <= 1'b0;
            FWD_DROP  <= 1'b0;
            ERP_START <= 1'b0;
        end else begin
            TX_GRANT  <= tx_grant;
            TX_DROP   <= TX_REQ & ~tx_grant;
            TX_HOLD   <= state_next == slp_pkg::SLP_CHK;
            SEND_FLAG <= (state_next == slp_pkg::SLP_CHK) |
                         (state_next == slp_pkg::SLP_ENA);
            SEND_DIS  <= state_next == slp_pkg::SLP_DIS;
            RX_ACCEPT <= rx_ok & ~rx_priv_drop;
            RX_DROP   <= RX_FRAME & ~(rx_ok & ~rx_priv_drop);
            RX_ACK    <= rx_ok;
            FWD_PASS  <= fwd_pass;
            FWD_DROP  <= fwd_drop;
            ERP_START <= enter_chk;
        end
    end

    // Port-up outranks the other alerts in one cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            ALERT_VALID <= 1'b0;
            ALERT_CODE  <= slp_pkg::AL_NONE;
        end else begin
            ALERT_VALID <= port_up | fwd_drop | rx_wrap_drop;
            if (port_up) ALERT_CODE <= slp_pkg::AL_PORT_UP;
            else if (fwd_drop) ALERT_CODE <= slp_pkg::AL_TGT_DOWN;
            else if (rx_wrap_drop) ALERT_CODE <= slp_pkg::AL_WRAP_RX;
            else ALERT_CODE <= slp_pkg::AL_NONE;
        end
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    wire [slp_pkg::STAT_W-1:0] stat_word = {
        err_latch_reg, peer_rst_seen_reg, ack_owed_reg, awaiting_ack_reg,
        receive_ready_owed_reg, awaiting_receive_ready_reg, rx_seq_reg,
        tx_seq_reg, usable_reg, mode_reg, state_reg};
    wire [31:0] rt0 = {alert_entry_valid[0], alert_out_port[0],
                       6'h00, alert_return_route[0], alert_tag[0]};
    wire [31:0] rt1 = {alert_entry_valid[1], alert_out_port[1],
                       6'h00, alert_return_route[1], alert_tag[1]};
    wire [31:0] rd_mux = hit_stat ? {17'h00000, stat_word} :
                         hit_rt0  ? rt0 :
                         hit_rt1  ? rt1 : 32'h00000000;

    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_reg <= 1'b0;
            PRDATA     <= 32'h00000000;
            PSLVERR    <= 1'b0;
        end else begin
            pready_reg <= PSEL & PENABLE & ~pready_reg;
            PRDATA     <= rd_mux;
            PSLVERR    <= PSEL & PENABLE & ~pready_reg & ~hit_any;
        end
    end
    assign PREADY = pready_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_ready_to_check: assert property (
        in_rdy & ERR_DET & ~port_rst & ~ERP_DISABLE & ~st_go
        |=> in_chk ##0 ERP_START)
        else $error("ready error did not enter check");
    a_check_holds: assert property (
        in_chk & ~ERP_DONE_OK & ~ERP_DONE_ALERT & ~port_rst &
        ~ERP_DISABLE |=> SEND_FLAG & TX_HOLD)
        else $error("check state not filling");
    a_check_rx_drop: assert property (
        RX_FRAME & rx_np & in_chk |=> RX_DROP & ~RX_ACK)
        else $error("check state acked a frame");
    a_priv_tx_seq: assert property (
        tx_priv_drop & ~enter_dis |=> TX_DROP & $stable(tx_seq_reg))
        else $error("privileged drop moved tx sequence");
    a_priv_rx_seq: assert property (
        rx_priv_drop & ~enter_dis |=> RX_ACK & RX_DROP &
        (rx_seq_reg == 2'($past(rx_seq_reg) + 2'h1)))
        else $error("privileged rx drop not acked");
    a_wrap_line_low: assert property (
        in_wrap |=> ~LINE_OUT)
        else $error("line driven in wrap");
    a_wrap_unusable: assert property (
        in_wrap |-> ~usable_reg)
        else $error("usable set in wrap");
    a_port_up_alert: assert property (
        $rose(usable_reg) |-> ALERT_VALID &
        (ALERT_CODE == slp_pkg::AL_PORT_UP))
        else $error("port up without alert");
    a_fwd_gate: assert property (
        fwd_drop |=> FWD_DROP & ~FWD_PASS & ALERT_VALID)
        else $error("forward gate wrong");
    a_dis_init: assert property (
        enter_dis & ~PEER_RST_RX & ~ERR_DET |=>
        (tx_seq_reg == 2'h0) & (rx_seq_reg == 2'h0) &
        awaiting_receive_ready_reg & receive_ready_owed_reg &
        ~awaiting_ack_reg & ~ack_owed_reg & ~peer_rst_seen_reg)
        else $error("disabled entry init wrong");
    a_unusable_tx: assert property (
        TX_REQ & ~usable_reg & ~tx_rst_ok |=> ~TX_GRANT)
        else $error("frame sent through unusable port");

    c_check_entry: cover property (in_rdy ##1 in_chk);
    c_priv_drop:   cover property (rx_priv_drop);
    c_port_up:     cover property ($rose(usable_reg));
    c_selftest:    cover property (st_go ##1 in_priv);

endmodule : slp_port_ctrl

// File: slp_remote.sv
`timescale 1ns/100ps
module slp_remote #(
    parameter int DLY = 2
) (
    input  wire logic clk,
    input  wire logic grant,
    output logic      ack_rx,
    output logic      rr_rx
);
    // Far port answers each granted frame with ack and pacing pairs
    logic [7:0] pend_reg = 8'h00;
    always @(posedge clk) begin
        pend_reg <= {pend_reg[6:0], grant};
    end
    assign ack_rx = pend_reg[DLY];
    assign rr_rx  = pend_reg[DLY];
endmodule : slp_remote

// File: serial_link_port_state_mode_control_bench.sv
`timescale 1ns/100ps
module serial_link_port_state_mode_control_bench;
    // ------------------------------------------------------------
    // Stimulus, observation and checking
    // ------------------------------------------------------------
    logic        CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
    logic        PWRITE = 1'b0, TXD_IN = 1'b0, LINE_IN = 1'b0;
    logic        wrap_b = 1'b0, tx_d = 1'b0;
    logic [7:0]  PADDR = 8'h00, lf = 8'h5d;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [1:0]  ALERT_CODE, al_seen = 2'h0;
    logic        PREADY, PSLVERR, LINE_OUT, RXD_OUT, TX_GRANT, TX_DROP;
    logic        ERP_START, ALERT_VALID, ACK_RX, RR_RX;
    logic        RX_ACK, RX_DROP, FWD_PASS, FWD_DROP, tx_rs = 1'b0;
    logic [1:0]  tx_ty = 2'h0, rx_ty = 2'h0, fw_ty = 2'h0;
    logic [24:0] su = 25'h0000000;
    logic [11:0] ev = 12'h000;
    logic [32:0] exp_q[$];
    int          n_mismatch = 0;
    int          n_tests = 0;
    slp_port_ctrl u_dut (.*, .ERR_DET(ev[0]), .PEER_RST_RX(ev[1]),
        .LINE_FAULT(ev[2]), .FLAG_RX(ev[3]), .ERP_DONE_OK(ev[4]),
        .ERP_DONE_ALERT(ev[5]), .ERP_DISABLE(ev[6]), .RESET_FRAME_RX(ev[7]),
        .TX_REQ(ev[8]), .TX_TYPE(tx_ty), .TX_IS_RESET(tx_rs),
        .SETUP_VALID(ev[9]), .SETUP_MODE(2'h3), .SETUP_PORT(1'b0),
        .SETUP_RX_PORT(su[24]), .SETUP_ROUTE(su[23:16]),
        .SETUP_TAG(su[15:0]), .RX_FRAME(ev[10]), .RX_TYPE(rx_ty),
        .RX_FOR_PORT(1'b0), .PAIR_SENT(1'b0), .FWD_REQ(ev[11]),
        .FWD_TYPE(fw_ty), .FWD_IS_RESET(1'b0), .TX_HOLD(), .SEND_FLAG(),
        .SEND_DIS(), .RX_ACCEPT());
    slp_remote u_far (.clk(CLK), .grant(TX_GRANT), .ack_rx(ACK_RX),
        .rr_rx(RR_RX));
    always #2.5 CLK = ~CLK;
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nxt
    task automatic chk(input logic [32:0] got, input logic [32:0] want);
        n_tests++;
        if (got !== want) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk
    task automatic conclude();
        $display("counts tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge CLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic pulse(input int i);
        @(posedge CLK);
        ev <= 12'h001 << i;
        @(posedge CLK);
        ev <= 12'h000;
        #1;
    endtask : pulse
    always @(posedge CLK) begin
        lf      <= nxt(lf);
        TXD_IN  <= lf[0];
        LINE_IN <= lf[4];
        tx_d    <= TXD_IN;
        if (ALERT_VALID === 1'b1)
            al_seen <= ALERT_CODE;
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
            chk({PSLVERR, PRDATA}, exp_q.pop_front());
        if (wrap_b) begin
            chk(RXD_OUT, tx_d);
            chk(LINE_OUT, 1'b0);
        end
    end
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        wrap_b <= 1'b1;
        rd(slp_pkg::OFS_STAT, 33'h608);
        rd(slp_pkg::OFS_ROUTE0, 33'h0);
        rd(8'h10, {1'b1, 32'h0});
        wrap_b <= 1'b0;
        $display("test reset and wrap done");
        apb(1'b1, slp_pkg::OFS_CTRL, 32'h2);
        rd(slp_pkg::OFS_STAT, 33'h604);
        apb(1'b1, slp_pkg::OFS_CTRL, 32'h1);
        pulse(3);
        rd(slp_pkg::OFS_STAT, 33'h616);
        chk(al_seen, slp_pkg::AL_PORT_UP);
        pulse(8);
        chk({TX_GRANT, TX_DROP}, 2'h2);
        tx_ty <= slp_pkg::FT_APP;
        pulse(8);
        chk({TX_GRANT, TX_DROP}, 2'h1);
        rx_ty <= slp_pkg::FT_APP;
        pulse(10);
        chk({RX_ACK, RX_DROP}, 2'h3);
        rd(slp_pkg::OFS_STAT, 33'h14b6);
        fw_ty <= slp_pkg::FT_APP;
        pulse(11);
        chk({FWD_PASS, FWD_DROP}, 2'h2);
        su <= {lf[3], lf, nxt(lf), lf};
        pulse(9);
        rd(slp_pkg::OFS_ROUTE0, {2'h1, su[24], 6'h00, su[23:0]});
        $display("test bring-up done");
        pulse(0);
        chk(ERP_START, 1'b1);
        repeat (4) @(posedge CLK);
        pulse(5);
        rd(slp_pkg::OFS_STAT, 33'h604);
        pulse(11);
        chk({FWD_PASS, FWD_DROP}, 2'h1);
        chk(ALERT_CODE, slp_pkg::AL_TGT_DOWN);
        tx_ty <= slp_pkg::FT_CONTROL;
        tx_rs <= 1'b1;
        pulse(8);
        chk({TX_GRANT, TX_DROP}, 2'h2);
        $display("test recovery done");
        conclude();
    end
endmodule : serial_link_port_state_mode_control_bench
